//--- core/cams_defines.svh
/*
 * timing and layout constants of the search memory block
 * assumes inclusion by bare name from the package and design file
 */
`ifndef CAMS_DEFINES_SVH
`define CAMS_DEFINES_SVH

`define CAMS_WORDS      32
`define CAMS_WIDTH      32
`define CAMS_AW         5
`define CAMS_BANK_LINES 16
`define CAMS_BANK_BIT   31
`define CAMS_WR_CYC     2
`define CAMS_WR_CYC_DC  3
`define CAMS_RAM_WORDS  256
`define CAMS_RAM_AW     8
`define CAMS_RAM_DW     8

`endif

//--- core/cams_pkg.sv
/*
 * types of the search memory block
 * assumes cams_defines.svh is on the include path
 */
`include "cams_defines.svh"

package cams_pkg;
    typedef enum logic [1:0] {
        CAMS_SINGLE,
        CAMS_MULTI,
        CAMS_FAST_MULTI,
        CAMS_RAM
    } cams_mode_e;

    typedef struct packed {
        logic                      found;
        logic [`CAMS_AW-1:0]       addr;
        logic [`CAMS_BANK_LINES-1:0] lines;
    } cams_result_s;

    typedef logic [`CAMS_WIDTH-1:0] cams_word_t;
endpackage

//--- core/cams_block.sv
/*
 * embedded_memory_block used as content_addressable_memory or as two
 * single-port RAM halves
 * assumes user logic on mclk_i drives all inputs; outputs on out clock except write_busy_o
 */
`timescale 1ns/10ps
`default_nettype none
`include "cams_defines.svh"

// Contract
// - one block hosts up to two independent single-port RAMs
// - every register except the stored entries and RAM bytes clears asynchronously from local, global or chip reset
// - search word compared with all entries in parallel, location returned
// - match flag high whenever search word matches some entry
// - search mode holds 32 entries of 32 bits
// - bits marked don't-care are ignored in comparison
// - single, multiple and fast multiple modes, encoded or unencoded
// - encoded output gives binary address of matching entry
// - unencoded output uses 16 lines, one bank per search
// - unencoded compares 31 bits, top bit selects bank of 16
// - bank one reports odd entries, bank zero even entries
// - single-match write takes two cycles, search one cycle
// - single-match gives encoded and unencoded results directly
// - multiple-match presents 16 lines per cycle, two cycles for 32
// - fast multiple-match valid in one cycle, 16 entries only
// - write takes two cycles, three with don't-cares, writer holds it
// - contents loadable at configuration or by runtime writes
// - optional registers on data, addresses and strobes; output always registered
// - input and output registers may use different clocks
// - RAM mode returns the stored byte per address, preset at configuration, writable; writes reach only bytes 0 to 31 of each half (5-bit write address)
// - one clock for input registers and write_busy_o, another for the other output registers
module cams_block #(
    parameter logic [`CAMS_WIDTH-1:0] INIT_WORD = 32'hFFFF_FFFF,
    parameter logic [`CAMS_WIDTH-1:0] INIT_CARE = 32'h0000_0000,
    parameter logic [5:0]             REG_SEL   = 6'h3F
) (
    input  wire logic                        mclk_i,
    input  wire logic                        out_clk_i,
    input  wire logic                        rstn_i,
    input  wire logic                        local_clr_i,
    input  wire logic                        global_clr_i,
    input  wire logic                        in_clk_en_i,
    input  wire logic                        out_clk_en_i,
    input  wire cams_pkg::cams_mode_e        mode_i,
    input  wire logic                        encoded_i,
    input  wire logic                        config_load_i,
    input  wire cams_pkg::cams_word_t        data_i,
    input  wire cams_pkg::cams_word_t        care_i,
    input  wire logic                        dont_care_i,
    input  wire logic [`CAMS_AW-1:0]         write_addr_i,
    input  wire logic                        write_request_i,
    input  wire logic                        read_request_i,
    input  wire logic                        ram_half_i,
    input  wire logic [`CAMS_RAM_AW-1:0]     read_addr_i,
    output logic                             match_o,
    output logic [`CAMS_AW-1:0]              match_addr_o,
    output logic [`CAMS_BANK_LINES-1:0]      match_lines_o,
    output logic                             bank_o,
    output logic [`CAMS_RAM_DW-1:0]          ram_data_o,
    output logic                             write_busy_o
);
    import cams_pkg::*;

    // ----------------------------------------------------------------
    // reset and storage
    // ----------------------------------------------------------------
    logic clr_n;
    assign clr_n = rstn_i & ~local_clr_i & ~global_clr_i;

    cams_word_t word_mem [`CAMS_WORDS];
    cams_word_t care_mem [`CAMS_WORDS];
    logic [`CAMS_RAM_DW-1:0] ram_mem [2][`CAMS_RAM_WORDS];

    // lookup-capable contents preset at configuration
    initial begin
        for (int i = 0; i < `CAMS_WORDS; i++) begin
            word_mem[i] = INIT_WORD;
            care_mem[i] = INIT_CARE;
        end
        for (int h = 0; h < 2; h++) begin
            for (int j = 0; j < `CAMS_RAM_WORDS; j++) begin
                ram_mem[h][j] = 8'(j);
            end
        end
    end

    // ----------------------------------------------------------------
    // optional input registers on mclk_i
    // ----------------------------------------------------------------
    cams_word_t data_reg;
    cams_word_t care_reg;
    logic [`CAMS_AW-1:0] waddr_reg;
    logic [`CAMS_RAM_AW-1:0] raddr_reg;
    logic wreq_reg;
    logic rreq_reg;
    logic dc_reg;
    logic half_reg;

    // capture inputs under input enable
    always_ff @(posedge mclk_i or negedge clr_n) begin
        if (!clr_n) begin
            data_reg  <= 32'h0000_0000;
            care_reg  <= 32'h0000_0000;
            waddr_reg <= 5'h00;
            raddr_reg <= 8'h00;
            wreq_reg  <= 1'b0;
            rreq_reg  <= 1'b0;
            dc_reg    <= 1'b0;
            half_reg  <= 1'b0;
        end else if (in_clk_en_i) begin
            data_reg  <= data_i;
            care_reg  <= care_i;
            waddr_reg <= write_addr_i;
            raddr_reg <= read_addr_i;
            wreq_reg  <= write_request_i;
            rreq_reg  <= read_request_i;
            dc_reg    <= dont_care_i;
            half_reg  <= ram_half_i;
        end
    end

    // bypass muxes select registered or direct path; data and care share one select, don't-care and half flags always registered
    cams_word_t s_data;
    cams_word_t s_care;
    logic [`CAMS_AW-1:0] s_waddr;
    logic [`CAMS_RAM_AW-1:0] s_raddr;
    logic s_wreq;
    logic s_rreq;
    assign s_data  = REG_SEL[0] ? data_reg  : data_i;
    assign s_care  = REG_SEL[0] ? care_reg  : care_i;
    assign s_raddr = REG_SEL[2] ? raddr_reg : read_addr_i;
    assign s_waddr = REG_SEL[3] ? waddr_reg : write_addr_i;
    assign s_wreq  = REG_SEL[4] ? wreq_reg  : write_request_i;
    assign s_rreq  = REG_SEL[5] ? rreq_reg  : read_request_i;

    // ----------------------------------------------------------------
    // write sequencer: two cycles, three with don't-cares
    // ----------------------------------------------------------------
    logic [1:0] wcnt_reg;
    logic       wr_commit;
    assign wr_commit = s_wreq && (wcnt_reg == 2'((dc_reg ? `CAMS_WR_CYC_DC
                                     : `CAMS_WR_CYC) - 1));

    // count held write cycles, restart when strobe drops
    always_ff @(posedge mclk_i or negedge clr_n) begin
        if (!clr_n) begin
            wcnt_reg <= 2'h0;
        end else if (in_clk_en_i) begin
            wcnt_reg <= (s_wreq && !wr_commit) ? wcnt_reg + 2'h1
                                               : 2'h0;
        end
    end

    // store word and mask, or a RAM byte in the selected half
    always_ff @(posedge mclk_i) begin
        if (in_clk_en_i && wr_commit) begin
            if (mode_i == CAMS_RAM) begin
                ram_mem[half_reg][{3'h0, s_waddr}] <=
                    s_data[`CAMS_RAM_DW-1:0];
            end else if (!config_load_i) begin
                word_mem[s_waddr] <= s_data;
                care_mem[s_waddr] <= dc_reg ? s_care : 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // parallel compare
    // ----------------------------------------------------------------
    function automatic logic hit(input cams_word_t w, input cams_word_t c,
                                 input cams_word_t k, input logic unenc);
        cams_word_t ign;
        ign = c;
        if (unenc) begin
            ign[`CAMS_BANK_BIT] = 1'b1;
        end
        return ((w ^ k) & ~ign) == 32'h0000_0000;
    endfunction

    logic [`CAMS_WORDS-1:0] hits;
    genvar g;
    generate
        for (g = 0; g < `CAMS_WORDS; g++) begin : g_cmp
            assign hits[g] = hit(word_mem[g], care_mem[g], s_data,
                                 !encoded_i);
        end
    endgenerate

    // fast mode uses only the lower 16 entries
    logic [`CAMS_WORDS-1:0] live;
    assign live = (mode_i == CAMS_FAST_MULTI) ?
                  {16'h0000, hits[15:0]} : hits;

    // lowest matching entry, binary address
    logic [`CAMS_AW-1:0] enc_addr;
    always_comb begin
        enc_addr = 5'h00;
        for (int i = `CAMS_WORDS - 1; i >= 0; i--) begin
            if (live[i]) begin
                enc_addr = 5'(i);
            end
        end
    end

    // ----------------------------------------------------------------
    // bank phase for two-cycle encoded-mode delivery
    // ----------------------------------------------------------------
    logic bank_sel;
    logic phase_reg;
    // second cycle of an encoded multi-match read shows the other half
    always_ff @(posedge mclk_i or negedge clr_n) begin
        if (!clr_n) begin
            phase_reg <= 1'b0;
        end else if (in_clk_en_i) begin
            phase_reg <= s_rreq && (mode_i == CAMS_MULTI) && !phase_reg;
        end
    end
    assign bank_sel = encoded_i ? phase_reg
                    : s_data[`CAMS_BANK_BIT];

    // pick odd or even entries, or half of the array
    logic [`CAMS_BANK_LINES-1:0] lines;
    always_comb begin
        lines = 16'h0000;
        for (int i = 0; i < `CAMS_BANK_LINES; i++) begin
            if (mode_i == CAMS_FAST_MULTI) begin
                lines[i] = live[i];
            end else if (!encoded_i) begin
                lines[i] = live[2 * i + int'(bank_sel)];
            end else begin
                lines[i] = live[16 * int'(bank_sel) + i];
            end
        end
    end

    cams_result_s res;
    assign res.found = |live;
    assign res.addr  = enc_addr;
    assign res.lines = lines;

    // ----------------------------------------------------------------
    // output registers on the output clock; write_busy_o on mclk_i
    // ----------------------------------------------------------------
    logic [`CAMS_RAM_DW-1:0] ram_q;
    assign ram_q = ram_mem[half_reg][s_raddr];

    // single mode and fast mode finish in one cycle after a search
    always_ff @(posedge out_clk_i or negedge clr_n) begin
        if (!clr_n) begin
            match_o       <= 1'b0;
            match_addr_o  <= 5'h00;
            match_lines_o <= 16'h0000;
            bank_o        <= 1'b0;
            ram_data_o    <= 8'h00;
        end else if (out_clk_en_i) begin
            if (s_rreq && mode_i != CAMS_RAM) begin
                match_o       <= res.found;
                match_addr_o  <= res.found ? res.addr : 5'h00;
                match_lines_o <= res.lines;
                bank_o        <= bank_sel;
            end
            if (s_rreq && mode_i == CAMS_RAM) begin
                ram_data_o <= ram_q;
            end
        end
    end

    // write in progress indicator
    always_ff @(posedge mclk_i or negedge clr_n) begin
        if (!clr_n) begin
            write_busy_o <= 1'b0;
        end else if (in_clk_en_i) begin
            write_busy_o <= s_wreq && !wr_commit;
        end
    end

endmodule // cams_block

`default_nettype wire

//--- test/cams_user_enc.sv
/*
 * fabric-side priority encoder for match lines
 * assumes lines come straight from the block
 */
`timescale 1ns/10ps
`default_nettype none
`include "cams_defines.svh"
module cams_user_enc (
    input  wire logic [`CAMS_BANK_LINES-1:0] lines_i,
    output logic [`CAMS_AW-1:0]             addr_o
);
    // lowest raised line wins
    always_comb begin
        addr_o = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (lines_i[i]) addr_o = 5'(i);
        end
    end
endmodule // cams_user_enc
`default_nettype wire

//--- test/cams_block_assertions.sv
/*
 * port checker for the search memory block
 * assumes one clock drives both register sides
 */
`timescale 1ns/10ps
`default_nettype none
module cams_block_assertions (
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic        local_clr_i,
    input wire logic        global_clr_i,
    input wire logic        out_clk_en_i,
    input wire logic        read_request_i,
    input wire logic        write_request_i,
    input wire logic        match_o,
    input wire logic [4:0]  match_addr_o,
    input wire logic [15:0] match_lines_o,
    input wire logic        write_busy_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i || local_clr_i || global_clr_i);
    // -------------------------------
    // clears, flags and holding
    // -------------------------------
    AST_LOCAL_CLR: assert property (disable iff (!rstn_i)
        local_clr_i |-> !match_o && match_addr_o == 5'h00 && !write_busy_o)
        else $error("outputs not cleared by local clear");
    AST_GLOBAL_CLR: assert property (disable iff (!rstn_i)
        global_clr_i |-> !match_o && match_lines_o == 16'h0000)
        else $error("outputs not cleared by global clear");
    AST_MISS_ADDR: assert property (
        !match_o |-> match_addr_o == 5'h00)
        else $error("address set without a match");
    AST_MISS_LINES: assert property (
        !match_o |-> match_lines_o == 16'h0000)
        else $error("lines set without a match");
    AST_HOLD: assert property (
        !out_clk_en_i |=> $stable(match_o) && $stable(match_addr_o))
        else $error("outputs moved with output enable low");
    AST_RESULT_CAUSE: assert property (
        $rose(match_o) |-> $past(read_request_i) ||
        $past(read_request_i, 2) || $past(read_request_i, 3))
        else $error("match rose without a search");
    AST_BUSY_CAUSE: assert property (
        $rose(write_busy_o) |-> $past(write_request_i, 2))
        else $error("busy rose without a held write");
    AST_BUSY_DROP: assert property (
        !write_request_i [*3] |=> !write_busy_o)
        else $error("busy stayed after write dropped");
endmodule // cams_block_assertions
bind cams_block cams_block_assertions u_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .local_clr_i(local_clr_i),
    .global_clr_i(global_clr_i), .out_clk_en_i(out_clk_en_i),
    .read_request_i(read_request_i), .write_request_i(write_request_i),
    .match_o(match_o), .match_addr_o(match_addr_o),
    .match_lines_o(match_lines_o), .write_busy_o(write_busy_o));
`default_nettype wire

//--- test/cams_block_tb.sv
/*
 * self-checking bench for the search memory block
 * assumes package, defines, block and partner compiled first
 */
`timescale 1ns/10ps
`default_nettype none
module cams_block_tb;
    import cams_pkg::*;
    typedef struct packed {
        cams_mode_e mode; logic enc; cams_word_t key; logic hit;
        logic [4:0] addr; logic [15:0] lines; logic ca; logic cl;
    } cams_row_s;
    logic mclk_i = 1'h0, rstn_i = 1'h0, local_clr_i = 1'h0;
    logic global_clr_i = 1'h0, in_clk_en_i = 1'h1, out_clk_en_i = 1'h1;
    logic encoded_i = 1'h1, config_load_i = 1'h0, dont_care_i = 1'h0;
    logic write_request_i = 1'h0, read_request_i = 1'h0;
    cams_mode_e mode_i = CAMS_SINGLE;
    cams_word_t data_i = 32'h0, care_i = 32'h0;
    logic [4:0] write_addr_i = 5'h00, match_addr_o, enc_addr;
    logic [15:0] match_lines_o;
    logic match_o, write_busy_o;
    int miscompares = 0, checks_done = 0, cycles = 0;
    cams_row_s rows [7] = '{
      '{CAMS_SINGLE,1'h1,32'h0000FA12,1'h1,5'h0C,16'h0,1'h1,1'h0},
      '{CAMS_SINGLE,1'h1,32'h00000000,1'h0,5'h00,16'h0,1'h1,1'h1},
      '{CAMS_SINGLE,1'h1,32'h0000AB77,1'h1,5'h03,16'h0,1'h1,1'h0},
      '{CAMS_SINGLE,1'h0,32'h0000FA12,1'h1,5'h00,16'h0040,1'h0,1'h1},
      '{CAMS_SINGLE,1'h0,32'h80000055,1'h1,5'h00,16'h0008,1'h0,1'h1},
      '{CAMS_MULTI,1'h1,32'h00001234,1'h1,5'h00,16'h0,1'h0,1'h0},
      '{CAMS_FAST_MULTI,1'h0,32'h00001234,1'h1,5'h0,16'h2220,1'h0,1'h1}};
    cams_block u_dut (
        .mclk_i(mclk_i), .out_clk_i(mclk_i), .rstn_i(rstn_i),
        .local_clr_i(local_clr_i), .global_clr_i(global_clr_i),
        .in_clk_en_i(in_clk_en_i), .out_clk_en_i(out_clk_en_i),
        .mode_i(mode_i), .encoded_i(encoded_i),
        .config_load_i(config_load_i), .data_i(data_i), .care_i(care_i),
        .dont_care_i(dont_care_i), .write_addr_i(write_addr_i),
        .write_request_i(write_request_i),
        .read_request_i(read_request_i), .ram_half_i(1'h0),
        .read_addr_i(8'h00), .match_o(match_o),
        .match_addr_o(match_addr_o), .match_lines_o(match_lines_o),
        .bank_o(), .ram_data_o(), .write_busy_o(write_busy_o));
    cams_user_enc u_enc (.lines_i(match_lines_o), .addr_o(enc_addr));
    // clock and hang guard
    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    // write held for n cycles, then released
    task automatic wr(logic [4:0] a, cams_word_t d, cams_word_t c, int n);
        @(posedge mclk_i);
        write_addr_i <= a;
        data_i <= d;
        care_i <= c;
        dont_care_i <= |c;
        write_request_i <= 1'h1;
        repeat (n) @(posedge mclk_i);
        write_request_i <= 1'h0;
        repeat (4) @(posedge mclk_i);
    endtask
    // one-cycle search strobe, results two edges later
    task automatic rd(cams_mode_e m, logic e, cams_word_t k);
        @(posedge mclk_i);
        mode_i <= m;
        encoded_i <= e;
        data_i <= k;
        read_request_i <= 1'h1;
        @(posedge mclk_i);
        read_request_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // -------------------------------
    // main sequence
    // -------------------------------
    initial begin
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'h1;
        wr(5'h0C, 32'h0000FA12, 32'h0, 3);
        wr(5'h03, 32'h0000AB00, 32'h000000FF, 4);
        wr(5'h07, 32'h00000055, 32'h0, 3);
        foreach (rows[i]) wr(5'h05 + 5'(i * 4), 32'h00001234, 32'h0, 3);
        foreach (rows[i]) begin
            rd(rows[i].mode, rows[i].enc, rows[i].key);
            chk("match", rows[i].hit, match_o);
            if (rows[i].ca) chk("addr", rows[i].addr, match_addr_o);
            if (rows[i].cl) chk("lines", rows[i].lines, match_lines_o);
        end
        chk("user enc", 5'h05, enc_addr);
        $display("test table done");
        rd(CAMS_SINGLE, 1'h1, 32'h0000FA12);
        out_clk_en_i <= 1'h0;
        rd(CAMS_SINGLE, 1'h1, 32'h0000AB77);
        chk("held addr", 5'h0C, match_addr_o);
        out_clk_en_i <= 1'h1;
        config_load_i <= 1'h1;
        wr(5'h0D, 32'h00000777, 32'h0, 3);
        config_load_i <= 1'h0;
        rd(CAMS_SINGLE, 1'h1, 32'h00000777);
        chk("refused write", 1'h0, match_o);
        wr(5'h0D, 32'h00000888, 32'h0, 1);
        rd(CAMS_SINGLE, 1'h1, 32'h00000888);
        chk("aborted write", 1'h0, match_o);
        $display("test refusals done");
        rd(CAMS_SINGLE, 1'h1, 32'h0000FA12);
        local_clr_i <= 1'h1;
        @(posedge mclk_i);
        local_clr_i <= 1'h0;
        #1;
        chk("local clr", 1'h0, match_o);
        rd(CAMS_SINGLE, 1'h1, 32'h0000FA12);
        global_clr_i <= 1'h1;
        @(posedge mclk_i);
        global_clr_i <= 1'h0;
        #1;
        chk("global clr", 5'h00, match_addr_o);
        rd(CAMS_SINGLE, 1'h1, 32'h0000FA12);
        chk("kept entry", 5'h0C, match_addr_o);
        $display("test clears done");
        summarize();
    end
endmodule // cams_block_tb
`default_nettype wire
